// file: hw/xu_pkg.sv
// constants and types shared by the exception unit and its helpers
// assumes a 32-bit address space, word-aligned stack pointer and vector base
`default_nettype none
package xu_pkg;
	// =======================================================
	// source map
	localparam int N_EXT = 8;
	localparam int N_TIMER = 23;
	localparam int N_SERIAL = 16;
	localparam int N_OTHER = 12;
	localparam int N_PERIPH = N_TIMER + N_SERIAL + N_OTHER;
	localparam int IDX_NMI = 0;
	localparam int IDX_BREAK = 1;
	localparam int IDX_DEBUG = 2;
	localparam int IDX_EXT = 3;
	localparam int IDX_PERIPH = IDX_EXT + N_EXT;
	localparam int N_SRC = IDX_PERIPH + N_PERIPH;
	localparam int IDX_W = $clog2(N_SRC);
	// =======================================================
	// levels and mask field
	localparam int LVL_W = 5;
	localparam int MASK_W = 4;
	localparam int MASK_LSB = 4;
	localparam logic [4:0] LVL_NMI = 5'h10;
	localparam logic [4:0] LVL_FIXED15 = 5'h0F;
	localparam logic [3:0] MASK_NMI = 4'hF;
	localparam logic [31:0] STACK_STEP = 32'h0000_0004;
	// =======================================================
	// vector numbers
	localparam logic [7:0] VEC_ILLEGAL = 8'h04;
	localparam logic [7:0] VEC_SLOT = 8'h06;
	localparam logic [7:0] VEC_ADDR_ERR = 8'h09;
	localparam logic [7:0] VEC_NMI = 8'h0B;
	localparam logic [7:0] VEC_BREAK = 8'h0C;
	localparam logic [7:0] VEC_DEBUG = 8'h0E;
	localparam logic [7:0] VEC_EXT_BASE = 8'h40;
	localparam logic [7:0] VEC_PERIPH_BASE = 8'h48;
	// =======================================================
	// types
	typedef enum logic [4:0] {
		K_OTHER, K_UNDEF, K_JMP, K_JSR, K_BRA, K_BSR, K_RTS, K_RTE, K_BFS,
		K_BTS, K_BSRF, K_BRAF, K_BT, K_BF, K_TRAP, K_CTRL_REG, K_CTRL_MEM
	} xu_kind_e;
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_PUSH_SW = 5'h02,
		S_PUSH_PC = 5'h04,
		S_FETCH = 5'h08,
		S_JUMP = 5'h10
	} xu_state_e;
	typedef enum logic [2:0] {
		C_NONE = 3'h0,
		C_INT = 3'h1,
		C_TRAP = 3'h2,
		C_SLOT = 3'h3,
		C_ILLEGAL = 3'h4,
		C_ADDR = 3'h5
	} xu_cause_e;
endpackage : xu_pkg
`default_nettype wire

// file: hw/xu_arbiter.sv
// picks the highest-level pending request; lowest index wins a tie
// assumes levels arrive packed, LVL_W bits per source, from the same clock
`default_nettype none
module xu_arbiter #(
	parameter int N = xu_pkg::N_SRC,
	parameter int IW = xu_pkg::IDX_W
) (
	input wire logic [N-1:0] req,
	input wire logic [N*xu_pkg::LVL_W-1:0] lvl,
	output logic hit,
	output logic [xu_pkg::LVL_W-1:0] best_lvl,
	output logic [IW-1:0] best_idx
);
	logic [xu_pkg::LVL_W-1:0] cur;

	// =======================================================
	// ranking scan
	always_comb begin
		hit = 1'b0;
		best_lvl = '0;
		best_idx = '0;
		cur = '0;
		for (int i = 0; i < N; i++) begin
			cur = lvl[i*xu_pkg::LVL_W +: xu_pkg::LVL_W];
			// strict compare so an equal level never displaces a lower index
			if (req[i] && (!hit || cur > best_lvl)) begin
				hit = 1'b1;
				best_lvl = cur;
				best_idx = IW'(i);
			end
		end
	end
endmodule : xu_arbiter
`default_nettype wire

// file: hw/xu_classify.sv
// sorts a decoded instruction kind into the attributes the unit acts on
// assumes the decode stage hands over one kind code per decoded instruction
`default_nettype none
module xu_classify (
	input wire xu_pkg::xu_kind_e kind,
	output logic delayed,
	output logic rewrites_pc,
	output logic int_off,
	output logic undef,
	output logic trap
);
	// =======================================================
	// decode helpers
	function automatic logic is_delayed(input xu_pkg::xu_kind_e k);
		case (k)
			xu_pkg::K_JMP, xu_pkg::K_JSR, xu_pkg::K_BRA, xu_pkg::K_BSR,
			xu_pkg::K_RTS, xu_pkg::K_RTE, xu_pkg::K_BFS, xu_pkg::K_BTS,
			xu_pkg::K_BSRF, xu_pkg::K_BRAF: is_delayed = 1'b1;
			default: is_delayed = 1'b0;
		endcase
	endfunction : is_delayed

	always_comb begin
		delayed = is_delayed(kind);
		// non-delayed pc writers join every delayed branch
		rewrites_pc = is_delayed(kind) || kind == xu_pkg::K_BT ||
			kind == xu_pkg::K_BF || kind == xu_pkg::K_TRAP;
		int_off = kind == xu_pkg::K_CTRL_REG || kind == xu_pkg::K_CTRL_MEM;
		undef = kind == xu_pkg::K_UNDEF;
		trap = kind == xu_pkg::K_TRAP;
	end
endmodule : xu_classify
`default_nettype wire

// file: hw/xu_exception_unit.sv
// cpu exception unit: interrupt acceptance, instruction exceptions, stacking
// assumes controller, decoder and memory port all run on clk
`default_nettype none
module xu_exception_unit #(
	parameter int N_EXT = xu_pkg::N_EXT,
	parameter int N_PERIPH = xu_pkg::N_PERIPH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic nmi_req,
	input wire logic break_req,
	input wire logic debug_interface_request,
	input wire logic [N_EXT-1:0] external_request_pins,
	input wire logic [N_EXT*4-1:0] ext_level,
	input wire logic [N_PERIPH-1:0] periph_req,
	input wire logic [N_PERIPH*4-1:0] periph_level,
	output logic int_ack,
	output logic [xu_pkg::IDX_W-1:0] int_ack_idx,
	input wire logic dec_valid,
	input wire xu_pkg::xu_kind_e dec_kind,
	input wire logic [31:0] dec_pc,
	input wire logic [31:0] dec_next_pc,
	input wire logic [31:0] slot_target,
	input wire logic [7:0] trap_vec,
	input wire logic addr_err,
	input wire logic [31:0] status_word,
	input wire logic [31:0] vector_base,
	input wire logic [31:0] stack_ptr,
	output logic dec_stall,
	output logic exc_take,
	output logic [2:0] exc_cause,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	output logic mask_load,
	output logic [3:0] mask_value,
	output logic sp_load,
	output logic [31:0] sp_value,
	output logic pc_load,
	output logic [31:0] pc_value
);
	localparam int NS = 3 + N_EXT + N_PERIPH;
	localparam int IW = xu_pkg::IDX_W;
	localparam int LW = xu_pkg::LVL_W;

	// =======================================================
	// source vector and level map
	function automatic logic [7:0] src_vector(input logic [IW-1:0] idx);
		if (idx == IW'(xu_pkg::IDX_NMI))
			src_vector = xu_pkg::VEC_NMI;
		else if (idx == IW'(xu_pkg::IDX_BREAK))
			src_vector = xu_pkg::VEC_BREAK;
		else if (idx == IW'(xu_pkg::IDX_DEBUG))
			src_vector = xu_pkg::VEC_DEBUG;
		else if (idx < IW'(xu_pkg::IDX_PERIPH))
			src_vector = xu_pkg::VEC_EXT_BASE + 8'(idx - IW'(xu_pkg::IDX_EXT));
		else
			src_vector = xu_pkg::VEC_PERIPH_BASE + 8'(idx - IW'(xu_pkg::IDX_PERIPH));
	endfunction : src_vector

	logic [NS-1:0] req_all;
	logic [NS*LW-1:0] lvl_all;
	assign req_all = {periph_req, external_request_pins,
		debug_interface_request, break_req, nmi_req};
	assign lvl_all[0 +: LW] = xu_pkg::LVL_NMI;
	assign lvl_all[LW +: LW] = xu_pkg::LVL_FIXED15;
	assign lvl_all[2*LW +: LW] = xu_pkg::LVL_FIXED15;

	genvar g;
	generate
		for (g = 3; g < NS; g++) begin : g_lvl
			// a four-bit field can never reach level 16
			if (g < 3 + N_EXT) begin : g_ext
				assign lvl_all[g*LW +: LW] = {1'b0, ext_level[(g-3)*4 +: 4]};
			end else begin : g_per
				assign lvl_all[g*LW +: LW] = {1'b0, periph_level[(g-3-N_EXT)*4 +: 4]};
			end
		end
	endgenerate

	logic arb_hit;
	logic [LW-1:0] arb_lvl;
	logic [IW-1:0] arb_idx;

	xu_arbiter #(.N(NS), .IW(IW)) u_arb (
		.req(req_all),
		.lvl(lvl_all),
		.hit(arb_hit),
		.best_lvl(arb_lvl),
		.best_idx(arb_idx)
	);

	logic c_delayed, c_rewrites, c_int_off, c_undef, c_trap;

	xu_classify u_cls (
		.kind(dec_kind),
		.delayed(c_delayed),
		.rewrites_pc(c_rewrites),
		.int_off(c_int_off),
		.undef(c_undef),
		.trap(c_trap)
	);

	// =======================================================
	// acceptance decision
	xu_pkg::xu_state_e state_r, state_nxt;
	logic slot_r, slot_nxt, intoff_r, intoff_nxt, ae_pend_r, ae_pend_nxt;
	logic [3:0] mask;
	logic int_ok, dec_go;
	logic take_slot, take_ill, take_trap, take_ae, take_int, take;

	assign mask = status_word[xu_pkg::MASK_LSB +: xu_pkg::MASK_W];
	// level 16 always beats a four-bit mask, the index test keeps that explicit
	assign int_ok = arb_hit && (arb_idx == IW'(xu_pkg::IDX_NMI) ||
		arb_lvl > {1'b0, mask});
	assign dec_go = ce && dec_valid && state_r == xu_pkg::S_IDLE;

	always_comb begin
		take_slot = dec_go && slot_r && (c_undef || c_rewrites);
		take_ill = dec_go && !slot_r && c_undef;
		take_trap = dec_go && !slot_r && c_trap;
		// slot holds back both, interrupt-off only interrupts
		take_ae = dec_go && !slot_r && !c_undef && !c_trap &&
			(addr_err || ae_pend_r);
		take_int = dec_go && !slot_r && !intoff_r && !c_undef && !c_trap &&
			!(addr_err || ae_pend_r) && int_ok;
		take = take_slot || take_ill || take_trap || take_ae || take_int;
	end

	assign exc_take = take;
	assign dec_stall = state_r != xu_pkg::S_IDLE;

	always_comb begin
		slot_nxt = slot_r;
		intoff_nxt = intoff_r;
		// an error arriving as the pending one is taken still stays pending
		ae_pend_nxt = addr_err || (ae_pend_r && !take_ae);
		if (take) begin
			slot_nxt = 1'b0;
			intoff_nxt = 1'b0;
		end else if (dec_go) begin
			slot_nxt = c_delayed && !slot_r;
			intoff_nxt = c_int_off;
		end
		if (take_ae)
			ae_pend_nxt = addr_err && ae_pend_r;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slot_r <= 1'b0;
			intoff_r <= 1'b0;
			ae_pend_r <= 1'b0;
		end else if (ce) begin
			slot_r <= slot_nxt;
			intoff_r <= intoff_nxt;
			ae_pend_r <= ae_pend_nxt;
		end
	end

	// =======================================================
	// stacking and vector fetch
	logic [31:0] addr_r, addr_nxt, wdata_r, wdata_nxt, stk_pc_r, stk_pc_nxt;
	logic [31:0] vaddr_r, vaddr_nxt, sp_r, sp_nxt, hand_r, hand_nxt;
	logic [7:0] vec;
	logic [2:0] cause_r, cause_nxt;
	logic ack_r, ack_nxt, mload_r, mload_nxt;
	logic [IW-1:0] ack_idx_r, ack_idx_nxt;
	logic [3:0] mval_r, mval_nxt;

	always_comb begin
		vec = xu_pkg::VEC_ADDR_ERR;
		if (take_slot)
			vec = xu_pkg::VEC_SLOT;
		else if (take_ill)
			vec = xu_pkg::VEC_ILLEGAL;
		else if (take_trap)
			vec = trap_vec;
		else if (take_int)
			vec = src_vector(arb_idx);
	end

	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		stk_pc_nxt = stk_pc_r;
		vaddr_nxt = vaddr_r;
		sp_nxt = sp_r;
		hand_nxt = hand_r;
		cause_nxt = cause_r;
		ack_nxt = 1'b0;
		ack_idx_nxt = ack_idx_r;
		mload_nxt = 1'b0;
		mval_nxt = mval_r;
		case (state_r)
			xu_pkg::S_IDLE: begin
				if (take) begin
					state_nxt = xu_pkg::S_PUSH_SW;
					addr_nxt = stack_ptr - xu_pkg::STACK_STEP;
					wdata_nxt = status_word;
					vaddr_nxt = vector_base + {22'h00_0000, vec, 2'b00};
					if (take_slot) begin
						stk_pc_nxt = slot_target;
						cause_nxt = xu_pkg::C_SLOT;
					end else if (take_ill) begin
						stk_pc_nxt = dec_pc;
						cause_nxt = xu_pkg::C_ILLEGAL;
					end else if (take_trap) begin
						stk_pc_nxt = dec_next_pc;
						cause_nxt = xu_pkg::C_TRAP;
					end else begin
						stk_pc_nxt = dec_pc;
						cause_nxt = take_int ? xu_pkg::C_INT : xu_pkg::C_ADDR;
					end
					if (take_int) begin
						ack_nxt = 1'b1;
						ack_idx_nxt = arb_idx;
						mload_nxt = 1'b1;
						// the field cannot hold 16, so the nmi leaves fifteen
						mval_nxt = arb_lvl[4] ? xu_pkg::MASK_NMI : arb_lvl[3:0];
					end
				end
			end
			xu_pkg::S_PUSH_SW: begin
				if (mem_ack) begin
					state_nxt = xu_pkg::S_PUSH_PC;
					addr_nxt = addr_r - xu_pkg::STACK_STEP;
					wdata_nxt = stk_pc_r;
				end
			end
			xu_pkg::S_PUSH_PC: begin
				if (mem_ack) begin
					state_nxt = xu_pkg::S_FETCH;
					sp_nxt = addr_r;
					addr_nxt = vaddr_r;
				end
			end
			xu_pkg::S_FETCH: begin
				if (mem_ack) begin
					state_nxt = xu_pkg::S_JUMP;
					hand_nxt = mem_rdata;
				end
			end
			xu_pkg::S_JUMP: state_nxt = xu_pkg::S_IDLE;
			default: state_nxt = xu_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= xu_pkg::S_IDLE;
			addr_r <= 32'h0000_0000;
			wdata_r <= 32'h0000_0000;
			stk_pc_r <= 32'h0000_0000;
			vaddr_r <= 32'h0000_0000;
			sp_r <= 32'h0000_0000;
			hand_r <= 32'h0000_0000;
			cause_r <= xu_pkg::C_NONE;
			ack_r <= 1'b0;
			ack_idx_r <= '0;
			mload_r <= 1'b0;
			mval_r <= 4'h0;
		end else if (ce) begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			stk_pc_r <= stk_pc_nxt;
			vaddr_r <= vaddr_nxt;
			sp_r <= sp_nxt;
			hand_r <= hand_nxt;
			cause_r <= cause_nxt;
			ack_r <= ack_nxt;
			ack_idx_r <= ack_idx_nxt;
			mload_r <= mload_nxt;
			mval_r <= mval_nxt;
		end
	end

	// =======================================================
	// outputs
	assign mem_req = state_r == xu_pkg::S_PUSH_SW || state_r == xu_pkg::S_PUSH_PC ||
		state_r == xu_pkg::S_FETCH;
	assign mem_we = state_r == xu_pkg::S_PUSH_SW || state_r == xu_pkg::S_PUSH_PC;
	assign mem_addr = addr_r;
	assign mem_wdata = wdata_r;
	assign int_ack = ack_r;
	assign int_ack_idx = ack_idx_r;
	assign mask_load = mload_r;
	assign mask_value = mval_r;
	// handler is entered directly, never through a delay slot
	assign pc_load = state_r == xu_pkg::S_JUMP;
	assign pc_value = hand_r;
	assign sp_load = state_r == xu_pkg::S_JUMP;
	assign sp_value = sp_r;
	assign exc_cause = cause_r;

	// =======================================================
	// checks
	logic higher_waiting;
	always_comb begin
		higher_waiting = 1'b0;
		for (int i = 0; i < NS; i++)
			if (req_all[i] && lvl_all[i*LW +: LW] > arb_lvl)
				higher_waiting = 1'b1;
	end

	a_pick_highest: assert property (@(posedge clk) disable iff (rst)
		take_int |-> !higher_waiting)
		else $error("a lower-level interrupt was taken over a higher one");
	a_mask_gate: assert property (@(posedge clk) disable iff (rst)
		take_int && arb_idx != IW'(xu_pkg::IDX_NMI) |-> arb_lvl > {1'b0, mask})
		else $error("maskable interrupt taken at or below the mask");
	a_nmi_mask15: assert property (@(posedge clk) disable iff (rst)
		take_int && nmi_req |=> mask_load && mask_value == 4'hF)
		else $error("nmi did not set the mask field to fifteen");
	a_push_order: assert property (@(posedge clk) disable iff (rst)
		ce && state_r == xu_pkg::S_PUSH_SW && mem_ack |=>
		state_r == xu_pkg::S_PUSH_PC && mem_addr == $past(mem_addr) - 32'h0000_0004)
		else $error("second push not four below the first");
	a_trap_pc: assert property (@(posedge clk) disable iff (rst)
		take_trap |=> state_r == xu_pkg::S_PUSH_SW && stk_pc_r == $past(dec_next_pc))
		else $error("trap stacked the wrong return address");
	a_slot_target: assert property (@(posedge clk) disable iff (rst)
		dec_go && slot_r && c_rewrites |=> cause_r == xu_pkg::C_SLOT &&
		stk_pc_r == $past(slot_target))
		else $error("pc writer in a slot did not raise the slot exception");
	a_slot_defers: assert property (@(posedge clk) disable iff (rst)
		dec_go && slot_r && (addr_err || int_ok) |->
		(!take_ae && !take_int) ##1 (ae_pend_r || !$past(addr_err)))
		else $error("exception accepted inside a delay slot");
	a_intoff_defers: assert property (@(posedge clk) disable iff (rst)
		dec_go && intoff_r && !slot_r && !c_undef && !c_trap && (addr_err || ae_pend_r) |->
		take_ae && !take_int)
		else $error("interrupt-off handling of the next instruction went wrong");
	a_vec_fetch: assert property (@(posedge clk) disable iff (rst)
		take_int |=> vaddr_r == $past(vector_base) + {22'h00_0000, $past(vec), 2'b00})
		else $error("vector entry address is not base plus four times number");
endmodule : xu_exception_unit
`default_nettype wire

// file: verif/xu_mem_model.sv
// stack and vector memory seen by the exception unit's memory port
// assumes one access at a time; a read returns its address plus a fixed offset
`default_nettype none
module xu_mem_model #(
	parameter logic [31:0] HOFS = 32'h4000_0000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] wait_cycles,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	// =======================================================
	// access log, read back by the bench
	logic [3:0] cnt_r;
	logic [31:0] last_r;
	logic [31:0] w_addr [2];
	logic [31:0] w_data [2];
	logic [31:0] rd_addr;
	logic wi;
	assign mem_ack = mem_req && (cnt_r == wait_cycles);
	// outside a read ack the data bus toggles so stale data never looks valid
	assign mem_rdata = (mem_ack && !mem_we) ? mem_addr + HOFS : ~last_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 4'h0;
			last_r <= 32'h0000_0000;
			wi <= 1'h0;
			rd_addr <= 32'h0000_0000;
		end else begin
			cnt_r <= (mem_req && !mem_ack) ? cnt_r + 4'h1 : 4'h0;
			last_r <= mem_rdata;
			if (mem_ack && mem_we) begin
				w_addr[wi] <= mem_addr;
				w_data[wi] <= mem_wdata;
				wi <= ~wi;
			end
			// the vector read closes an exception, so the next push is slot 0
			if (mem_ack && !mem_we) begin
				rd_addr <= mem_addr;
				wi <= 1'h0;
			end
		end
	end
endmodule : xu_mem_model
`default_nettype wire

// file: verif/xu_exception_unit_test.sv
// bench for the exception unit: one task per scenario, one closing report
// assumes xu_mem_model answers the stack pushes and the vector reads
`default_nettype none
module xu_exception_unit_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] SP0 = 32'h0000_8000;
	localparam logic [31:0] VBASE0 = 32'h0000_1000;
	localparam logic [31:0] HOFS = 32'h4000_0000;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic nmi_req = 1'h0, break_req = 1'h0, debug_interface_request = 1'h0;
	logic [7:0] external_request_pins = '0;
	logic [31:0] ext_level = '0;
	logic [50:0] periph_req = '0;
	logic [203:0] periph_level = '0;
	logic dec_valid = 1'h0, addr_err = 1'h0, ce = 1'h1;
	xu_pkg::xu_kind_e dec_kind = xu_pkg::K_OTHER;
	logic [31:0] dec_pc = '0, dec_next_pc = '0, slot_target = '0, status_word = '0;
	logic [7:0] trap_vec = 8'h21;
	logic [3:0] mem_wait = 4'h0;
	logic int_ack, dec_stall, exc_take, mem_req, mem_we, mem_ack, mask_load, sp_load, pc_load;
	logic [5:0] int_ack_idx;
	logic [2:0] exc_cause;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, sp_value, pc_value;
	logic [3:0] mask_value;
	int fails = 0;
	int num_checks = 0;
	always #25 clk = ~clk;
	// =======================================================
	// design and memory partner
	xu_exception_unit dut (.clk, .rst, .ce, .nmi_req, .break_req, .debug_interface_request,
		.external_request_pins, .ext_level, .periph_req, .periph_level, .int_ack, .int_ack_idx,
		.dec_valid, .dec_kind, .dec_pc, .dec_next_pc, .slot_target, .trap_vec, .addr_err,
		.status_word, .vector_base(VBASE0), .stack_ptr(SP0), .dec_stall, .exc_take, .exc_cause,
		.mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .mask_load, .mask_value,
		.sp_load, .sp_value, .pc_load, .pc_value);
	xu_mem_model #(.HOFS(HOFS)) mdl (.clk, .rst, .wait_cycles(mem_wait), .mem_req, .mem_we,
		.mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
	// =======================================================
	// shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test
	task automatic idle_edge();
		@(posedge clk);
		dec_valid <= 1'h0;
		addr_err <= 1'h0;
	endtask : idle_edge
	task automatic setup(input logic [3:0] m, input logic [3:0] w);
		idle_edge();
		status_word <= {24'h00_0000, m, 4'h3};
		mem_wait <= w;
	endtask : setup
	task automatic offer(input xu_pkg::xu_kind_e k, input logic [31:0] pc, input logic ae,
		input logic exp_take);
		@(posedge clk);
		dec_valid <= 1'h1;
		dec_kind <= k;
		dec_pc <= pc;
		dec_next_pc <= pc + 32'h0000_0002;
		slot_target <= pc + 32'h0000_0040;
		addr_err <= ae;
		#1;
		check("exc_take", exc_take, exp_take);
	endtask : offer
	task automatic expect_exc(input logic [2:0] cause, input logic [31:0] spc,
		input logic [7:0] vec, input logic is_int, input logic [3:0] mask, input logic [5:0] idx);
		int n;
		idle_edge();
		if (is_int) begin
			nmi_req <= 1'h0;
			break_req <= 1'h0;
			debug_interface_request <= 1'h0;
			external_request_pins <= '0;
			periph_req <= '0;
		end
		#1;
		check("int_ack", int_ack, is_int);
		check("mask_load", mask_load, is_int);
		if (is_int) begin
			check("int_ack_idx", int_ack_idx, idx);
			check("mask_value", mask_value, mask);
		end
		n = 0;
		while (pc_load !== 1'h1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n >= 40) begin
			fails++;
			$display("unexpected pc_load: expected 1 seen 0");
			stop_test();
		end
		check("handler", pc_value, VBASE0 + {22'h00_0000, vec, 2'h0} + HOFS);
		check("vector addr", mdl.rd_addr, VBASE0 + {22'h00_0000, vec, 2'h0});
		check("sp_load", sp_load, 1'h1);
		check("sp_value", sp_value, SP0 - 32'h0000_0008);
		check("dec_stall", dec_stall, 1'h1);
		check("exc_cause", exc_cause, cause);
		check("status push addr", mdl.w_addr[0], SP0 - 32'h0000_0004);
		check("status push data", mdl.w_data[0], status_word);
		check("pc push addr", mdl.w_addr[1], SP0 - 32'h0000_0008);
		check("pc push data", mdl.w_data[1], spc);
	endtask : expect_exc
	// =======================================================
	// scenarios
	task automatic t_instr();
		xu_pkg::xu_kind_e br [10] = '{xu_pkg::K_JMP, xu_pkg::K_JSR, xu_pkg::K_BRA,
			xu_pkg::K_BSR, xu_pkg::K_RTS, xu_pkg::K_RTE, xu_pkg::K_BFS, xu_pkg::K_BTS,
			xu_pkg::K_BSRF, xu_pkg::K_BRAF};
		xu_pkg::xu_kind_e sl [5] = '{xu_pkg::K_UNDEF, xu_pkg::K_BT, xu_pkg::K_BF,
			xu_pkg::K_TRAP, xu_pkg::K_JSR};
		setup(4'h0, 4'h2);
		// with the enable low the trap offer must leave no trace
		ce <= 1'h0;
		offer(xu_pkg::K_TRAP, 32'h0000_0100, 1'h0, 1'h0);
		idle_edge();
		ce <= 1'h1;
		offer(xu_pkg::K_TRAP, 32'h0000_0100, 1'h0, 1'h1);
		expect_exc(xu_pkg::C_TRAP, 32'h0000_0102, 8'h21, 1'h0, 4'h0, 6'h00);
		offer(xu_pkg::K_UNDEF, 32'h0000_0200, 1'h0, 1'h1);
		expect_exc(xu_pkg::C_ILLEGAL, 32'h0000_0200, xu_pkg::VEC_ILLEGAL, 1'h0, 4'h0, 6'h00);
		for (int i = 0; i < 10; i++) begin
			offer(br[i], 32'h0000_0300 + 32'(i * 8), 1'h0, 1'h0);
			offer(sl[i % 5], 32'h0000_0302 + 32'(i * 8), 1'h0, 1'h1);
			expect_exc(xu_pkg::C_SLOT, 32'h0000_0342 + 32'(i * 8), xu_pkg::VEC_SLOT, 1'h0, 4'h0,
				6'h00);
		end
		$display("instruction exceptions done");
	endtask : t_instr
	task automatic t_levels();
		setup(4'h5, 4'h0);
		external_request_pins[2] <= 1'h1;
		ext_level[11:8] <= 4'h5;
		offer(xu_pkg::K_OTHER, 32'h0000_0400, 1'h0, 1'h0);
		idle_edge();
		ext_level[11:8] <= 4'h6;
		offer(xu_pkg::K_OTHER, 32'h0000_0404, 1'h0, 1'h1);
		expect_exc(xu_pkg::C_INT, 32'h0000_0404, 8'h42, 1'h1, 4'h6, 6'h05);
		setup(4'hF, 4'h2);
		nmi_req <= 1'h1;
		offer(xu_pkg::K_OTHER, 32'h0000_0500, 1'h0, 1'h1);
		expect_exc(xu_pkg::C_INT, 32'h0000_0500, xu_pkg::VEC_NMI, 1'h1, 4'hF, 6'h00);
		setup(4'hE, 4'h0);
		debug_interface_request <= 1'h1;
		external_request_pins[0] <= 1'h1;
		ext_level[3:0] <= 4'hF;
		offer(xu_pkg::K_OTHER, 32'h0000_0510, 1'h0, 1'h1);
		expect_exc(xu_pkg::C_INT, 32'h0000_0510, xu_pkg::VEC_DEBUG, 1'h1, 4'hF, 6'h02);
		setup(4'h0, 4'h1);
		break_req <= 1'h1;
		periph_req[5] <= 1'h1;
		periph_level[23:20] <= 4'hE;
		offer(xu_pkg::K_OTHER, 32'h0000_0520, 1'h0, 1'h1);
		expect_exc(xu_pkg::C_INT, 32'h0000_0520, xu_pkg::VEC_BREAK, 1'h1, 4'hF, 6'h01);
		idle_edge();
		external_request_pins[0] <= 1'h1;
		ext_level[3:0] <= 4'h7;
		periph_req[5] <= 1'h1;
		periph_level[23:20] <= 4'h9;
		offer(xu_pkg::K_OTHER, 32'h0000_0530, 1'h0, 1'h1);
		expect_exc(xu_pkg::C_INT, 32'h0000_0530, 8'h4D, 1'h1, 4'h9, 6'h10);
		$display("interrupt levels done");
	endtask : t_levels
	task automatic t_defer();
		setup(4'h0, 4'h1);
		offer(xu_pkg::K_BRA, 32'h0000_0600, 1'h0, 1'h0);
		idle_edge();
		external_request_pins[4] <= 1'h1;
		ext_level[19:16] <= 4'h3;
		offer(xu_pkg::K_CTRL_MEM, 32'h0000_0602, 1'h1, 1'h0);
		offer(xu_pkg::K_OTHER, 32'h0000_0604, 1'h0, 1'h1);
		expect_exc(xu_pkg::C_ADDR, 32'h0000_0604, xu_pkg::VEC_ADDR_ERR, 1'h0, 4'h0, 6'h00);
		offer(xu_pkg::K_OTHER, 32'h0000_0610, 1'h0, 1'h1);
		expect_exc(xu_pkg::C_INT, 32'h0000_0610, 8'h44, 1'h1, 4'h3, 6'h07);
		offer(xu_pkg::K_CTRL_REG, 32'h0000_0620, 1'h0, 1'h0);
		idle_edge();
		external_request_pins[4] <= 1'h1;
		offer(xu_pkg::K_OTHER, 32'h0000_0622, 1'h0, 1'h0);
		offer(xu_pkg::K_OTHER, 32'h0000_0624, 1'h0, 1'h1);
		expect_exc(xu_pkg::C_INT, 32'h0000_0624, 8'h44, 1'h1, 4'h3, 6'h07);
		$display("deferred acceptance done");
	endtask : t_defer
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		#1;
		check("dec_stall", dec_stall, 1'h0);
		t_instr();
		t_levels();
		t_defer();
		stop_test();
	end
endmodule : xu_exception_unit_test
`default_nettype wire
